// ---- pfoc_consts.vh ----
// Register map, field positions, reset values and timing counts.
`ifndef PFOC_CONSTS_VH
`define PFOC_CONSTS_VH
`define PFOC_OFS_CONTROL 16'hF400
`define PFOC_OFS_KEY 16'hF410
`define PFOC_OFS_ADDR 16'hF420
`define PFOC_OFS_DATA 16'hF430
`define PFOC_OFS_SRC 16'hF440
`define PFOC_OFS_PROT 16'hF450
`define PFOC_ALIAS_PLAIN 2'h0
`define PFOC_ALIAS_CLR 2'h1
`define PFOC_ALIAS_SET 2'h2
`define PFOC_ALIAS_INV 2'h3
`define PFOC_BIT_START 15
`define PFOC_BIT_ARM 14
`define PFOC_BIT_ERR 13
`define PFOC_BIT_LVERR 12
`define PFOC_BIT_LVACT 11
`define PFOC_OP_MSB 3
`define PFOC_OP_NOP0 4'h0
`define PFOC_OP_WORD 4'h1
`define PFOC_OP_NOP2 4'h2
`define PFOC_OP_ROW 4'h3
`define PFOC_OP_PAGE 4'h4
`define PFOC_OP_ALL 4'h5
`define PFOC_OP_NOP6 4'h6
`define PFOC_RST_WORD 32'h00000000
`define PFOC_KEY_FIRST 32'hAA996655
`define PFOC_KEY_SECOND 32'h556699AA
`define PFOC_PAGE_BYTES 4096
`define PFOC_ROW_BYTES 512
`define PFOC_PAGE_SHIFT 12
`define PFOC_ROW_SHIFT 9
`define PFOC_CLK_MHZ 50
`define PFOC_WORD_US 20
`define PFOC_ROW_US 2000
`define PFOC_PAGE_US 20000
`define PFOC_ALL_US 80000
`endif

// ---- pfoc_program_flash_op_controller.v ----
// Flash program/erase sequencer with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "pfoc_consts.vh"
module pfoc_program_flash_op_controller #(
    parameter NPAGES = 64,
    parameter WORD_CYC = `PFOC_WORD_US * `PFOC_CLK_MHZ,
    parameter ROW_CYC = `PFOC_ROW_US * `PFOC_CLK_MHZ,
    parameter PAGE_CYC = `PFOC_PAGE_US * `PFOC_CLK_MHZ,
    parameter ALL_CYC = `PFOC_ALL_US * `PFOC_CLK_MHZ
) (
    input wire clk,
    input wire srst,
    input wire por,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire [NPAGES-1:0] page_protect,
    input wire low_supply,
    input wire flash_done,
    input wire flash_fail,
    output reg flash_go,
    output reg [3:0] flash_op,
    output reg [31:0] flash_addr,
    output reg [31:0] flash_wdata,
    output reg [31:0] flash_src,
    output wire detector_enable,
    output wire busy
);

    localparam ST_IDLE = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_DONE = 2'd2;

    // Merge a write into a register according to its alias slot.
    function [31:0] alias_merge;
        input [31:0] cur;
        input [31:0] wd;
        input [1:0] slot;
        begin
            case (slot)
                `PFOC_ALIAS_CLR: alias_merge = cur & ~wd;
                `PFOC_ALIAS_SET: alias_merge = cur | wd;
                `PFOC_ALIAS_INV: alias_merge = cur ^ wd;
                default: alias_merge = wd;
            endcase
        end
    endfunction

    // Map an address to a page index of the array.
    function [31:0] page_of;
        input [31:0] a;
        begin
            page_of = a >> `PFOC_PAGE_SHIFT;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase capture.
    reg wr_pend_q;
    reg rd_pend_q;
    reg [15:0] addr_q;
    wire take = hsel & hready & htrans[1];

    // The slave never stalls, so every transfer completes in one data phase.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge clk) begin
        if (srst || por) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 16'h0000;
        end else begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            if (take) begin
                addr_q <= haddr[15:0];
            end
        end
    end

    wire [1:0] slot = addr_q[3:2];
    wire [15:0] base = {addr_q[15:4], 4'h0};
    wire wr_ctl = wr_pend_q & (base == `PFOC_OFS_CONTROL);
    wire wr_key = wr_pend_q & (addr_q == `PFOC_OFS_KEY);
    wire wr_adr = wr_pend_q & (base == `PFOC_OFS_ADDR);
    wire wr_dat = wr_pend_q & (addr_q == `PFOC_OFS_DATA);
    wire wr_src = wr_pend_q & (addr_q == `PFOC_OFS_SRC);

    ////////////////////////////////////////////////////////////////////////
    // Control register state.
    reg start_q;
    reg arm_q;
    reg err_q;
    reg lverr_q;
    reg lvact_q;
    reg [3:0] opsel_q;
    reg [1:0] key_q;
    reg [1:0] state_q;
    reg [31:0] cnt_q;
    reg [3:0] run_op_q;
    reg lock_all_q;

    wire [31:0] ctl_view = {16'h0000, start_q, arm_q, err_q, lverr_q,
        lvact_q, 7'h00, opsel_q};
    wire [31:0] ctl_new = alias_merge(ctl_view, hwdata, slot);
    assign busy = (state_q != ST_IDLE);
    assign detector_enable = arm_q;

    // Unlock only holds when the very previous two accesses were the keys.
    wire unlocked = (key_q == 2'd2);
    wire start_req = wr_ctl & ctl_new[`PFOC_BIT_START] & ~start_q
        & arm_q & unlocked & ~busy;

    // Key sequence tracker: any bus access other than the next key cancels.
    always @(posedge clk) begin
        if (srst || por) begin
            key_q <= 2'd0;
        end else if (wr_key && key_q == 2'd0
                     && hwdata == `PFOC_KEY_FIRST) begin
            key_q <= 2'd1;
        end else if (wr_key && key_q == 2'd1
                     && hwdata == `PFOC_KEY_SECOND) begin
            key_q <= 2'd2;
        end else if (wr_pend_q | rd_pend_q) begin
            key_q <= 2'd0;
        end
    end

    // Protection check for the selected target.
    reg denied;
    always @* begin
        denied = 1'b0;
        case (opsel_q)
            `PFOC_OP_ALL: denied = |page_protect;
            `PFOC_OP_PAGE, `PFOC_OP_ROW, `PFOC_OP_WORD:
                denied = (page_of(flash_addr) < NPAGES)
                    ? page_protect[page_of(flash_addr)] : 1'b1;
            default: denied = 1'b0;
        endcase
    end

    // Duration for each operation code.
    reg [31:0] dur;
    always @* begin
        case (opsel_q)
            `PFOC_OP_WORD: dur = WORD_CYC;
            `PFOC_OP_ROW: dur = ROW_CYC;
            `PFOC_OP_PAGE: dur = PAGE_CYC;
            `PFOC_OP_ALL: dur = ALL_CYC;
            default: dur = 32'h00000001;
        endcase
    end
    wire real_op = (opsel_q == `PFOC_OP_WORD) | (opsel_q == `PFOC_OP_ROW)
        | (opsel_q == `PFOC_OP_PAGE) | (opsel_q == `PFOC_OP_ALL);

    ////////////////////////////////////////////////////////////////////////
    // Arm gate: the only control bit touched by device reset.
    always @(posedge clk) begin
        if (srst || por) begin
            arm_q <= 1'b0;
        end else if (wr_ctl) begin
            arm_q <= ctl_new[`PFOC_BIT_ARM];
        end
    end

    // Operation select and the other control bits survive device reset.
    always @(posedge clk) begin
        if (por) begin
            opsel_q <= 4'h0;
        end else if (wr_ctl && !arm_q && !busy) begin
            opsel_q <= ctl_new[`PFOC_OP_MSB:0];
        end
    end

    // Low-voltage live status follows the detector while it is powered.
    always @(posedge clk) begin
        if (por) begin
            lvact_q <= 1'b0;
        end else if (start_req && opsel_q == `PFOC_OP_NOP0) begin
            lvact_q <= 1'b0;
        end else if (arm_q) begin
            lvact_q <= low_supply;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: start, timed run, completion, flag update.
    always @(posedge clk) begin
        if (por) begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
            err_q <= 1'b0;
            lverr_q <= 1'b0;
            cnt_q <= 32'h00000000;
            run_op_q <= 4'h0;
            lock_all_q <= 1'b0;
            flash_go <= 1'b0;
            flash_op <= 4'h0;
        end else begin
            flash_go <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_req) begin
                        start_q <= 1'b1;
                        run_op_q <= opsel_q;
                        cnt_q <= dur;
                        lock_all_q <= denied;
                        if (opsel_q == `PFOC_OP_NOP0) begin
                            err_q <= 1'b0;
                            lverr_q <= 1'b0;
                        end
                        if (real_op && !denied) begin
                            flash_go <= 1'b1;
                            flash_op <= opsel_q;
                        end
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Low supply during a live operation is latched.
                    if (arm_q && low_supply && !lock_all_q
                        && (run_op_q == `PFOC_OP_WORD
                        || run_op_q == `PFOC_OP_ROW
                        || run_op_q == `PFOC_OP_PAGE
                        || run_op_q == `PFOC_OP_ALL)) begin
                        lverr_q <= 1'b1;
                    end
                    if (cnt_q != 32'h00000000) begin
                        cnt_q <= cnt_q - 32'h00000001;
                    end
                    if (cnt_q <= 32'h00000001 || flash_done) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Protected targets and array faults count as failures.
                    if ((lock_all_q || flash_fail) && run_op_q != 4'h0
                        && run_op_q != `PFOC_OP_NOP2
                        && run_op_q != `PFOC_OP_NOP6) begin
                        err_q <= 1'b1;
                    end
                    start_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and source registers, both cleared by device reset.
    always @(posedge clk) begin
        if (srst || por) begin
            flash_addr <= `PFOC_RST_WORD;
            flash_src <= `PFOC_RST_WORD;
        end else begin
            if (wr_adr && !busy) begin
                flash_addr <= alias_merge(flash_addr, hwdata, slot);
            end
            if (wr_src) begin
                flash_src <= hwdata;
            end
        end
    end

    // Program data is deliberately outside the device reset.
    always @(posedge clk) begin
        if (por) begin
            flash_wdata <= `PFOC_RST_WORD;
        end else if (wr_dat) begin
            flash_wdata <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data is returned combinationally in the data phase.
    always @* begin
        hrdata = 32'h00000000;
        if (rd_pend_q) begin
            case (addr_q)
                `PFOC_OFS_CONTROL: hrdata = ctl_view;
                `PFOC_OFS_KEY: hrdata = 32'h00000000;
                `PFOC_OFS_ADDR: hrdata = flash_addr;
                `PFOC_OFS_DATA: hrdata = flash_wdata;
                `PFOC_OFS_SRC: hrdata = flash_src;
                default: hrdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Usage notes for software and for whoever integrates this block.
    //
    // The register slave never inserts wait states. A write lands at the
    // edge that closes its data phase, so a read issued right behind it
    // already sees the new value. Reads return data combinationally during
    // the data phase and only at the exact base offsets; the alias slots
    // of the control and address registers are write-only views.
    //
    // The unlock tracker counts bus accesses, not cycles. Idle cycles
    // between the two key writes and the start write are harmless, but any
    // other access in between, a read included, cancels the unlock. This
    // trades a little convenience for protection against a stray write
    // that happens to hit the control register with the start bit set.
    //
    // The arm gate must be set before the start write and stays set after
    // it; a plain start write must carry the gate bit as well. Because the
    // operation select is frozen while the gate is set, software changes
    // the operation by clearing the gate, writing the code, and arming
    // again. The address register is frozen only while busy.
    //
    // A protected target is never handed to the array. The sequencer still
    // runs its timed window so that software sees the same start-to-done
    // behaviour, and the error flag is set when that window ends. A fault
    // reported by the array is sampled in the completion cycle only, so
    // the array must hold its fail level into the cycle that follows the done
    // pulse or the expiry of the cycle count.
    //
    // The cycle counts are upper bounds for each operation. An array that
    // finishes early may cut the wait short with its done pulse; one that
    // never reports done is covered by the count alone. The counts default
    // to the nominal durations at the nominal clock and are parameters so
    // that a simulation can shorten them.
    //
    // The low-voltage error flag is latched only while a real operation
    // runs with the detector powered. The live status bit follows the
    // detector whenever the gate is set and freezes when it is cleared,
    // because an unpowered detector gives no meaningful level. A start with
    // the no-operation code zero clears all three status flags.
    //
    // Device reset clears the arm gate, the unlock state, the address and
    // the source register. Power-on reset also clears everything else,
    // including the program data word and the operation select, and it
    // aborts any operation in flight. A device reset alone during an
    // operation lets the sequencer finish, but the gate is dropped, so the
    // detector is unpowered for the rest of that operation.
    //
    // The protection offset is reserved in the map and has no storage; a
    // write there is ignored and a read returns zero like any unmapped
    // offset.

endmodule // pfoc_program_flash_op_controller

// ---- pfoc_props.sv ----
// Port-level assertions for the flash sequencer.
`timescale 1ns/1ps
module pfoc_props (
    input wire clk,
    input wire srst,
    input wire por,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire flash_go,
    input wire [3:0] flash_op,
    input wire [31:0] flash_addr,
    input wire detector_enable,
    input wire busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst || por);
    reg rd_q;
    reg [15:0] ra_q;
    // Remember read address phases so the data phase can be judged.
    always @(posedge clk) begin
        rd_q <= hsel && hready && htrans[1] && !hwrite;
        ra_q <= haddr[15:0];
    end
    ////////////////////////////////////////////////////////////////////
    property p_key_rd;
        rd_q && ra_q == 16'hF410 |-> hrdata == 32'h00000000;
    endproperty
    a_key_rd: assert property (p_key_rd)
        else $error("key register read back nonzero");
    property p_ctl_rd;
        rd_q && ra_q == 16'hF400 |-> hrdata[31:16] == 16'h0000
            && hrdata[10:4] == 7'h00;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd)
        else $error("unused control bits read nonzero");
    property p_go_arm;
        flash_go |-> detector_enable;
    endproperty
    a_go_arm: assert property (p_go_arm)
        else $error("operation launched with the gate clear");
    property p_go_pulse;
        flash_go |=> !flash_go [*4];
    endproperty
    a_go_pulse: assert property (p_go_pulse)
        else $error("launch pulse repeated");
    property p_go_busy;
        flash_go |-> busy;
    endproperty
    a_go_busy: assert property (p_go_busy)
        else $error("launch without busy");
    property p_no_restart;
        flash_go |-> !$past(busy);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("second launch while busy");
    property p_op_hold;
        busy && $past(busy) |-> $stable(flash_op) && $stable(flash_addr);
    endproperty
    a_op_hold: assert property (p_op_hold)
        else $error("operation or address changed while busy");
    property p_srst_arm;
        @(posedge clk) disable iff (por) srst |=> !detector_enable;
    endproperty
    a_srst_arm: assert property (p_srst_arm)
        else $error("gate survived device reset");
endmodule // pfoc_props
bind pfoc_program_flash_op_controller pfoc_props chk_u (.clk(clk),
    .srst(srst), .por(por), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .flash_go(flash_go), .flash_op(flash_op), .flash_addr(flash_addr),
    .detector_enable(detector_enable), .busy(busy));

// ---- pfoc_flash_model.sv ----
// Behavioural model of the flash array behind the sequencer.
`timescale 1ns/1ps
module pfoc_flash_model (
    input wire clk,
    input wire flash_go,
    input wire slow,
    input wire fail_mode,
    output logic flash_done,
    output wire flash_fail
);
    logic [3:0] cnt_q = 4'h0;
    initial flash_done = 1'b0;
    // The array reports failure as a level read at completion.
    assign flash_fail = fail_mode;
    // A prompt array signals done early; a slow one never does, so the
    // sequencer must fall back on its own cycle count.
    always @(posedge clk) begin
        flash_done <= !slow && cnt_q == 4'h1;
        if (flash_go)
            cnt_q <= 4'h3;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end
endmodule // pfoc_flash_model

// ---- tb_top.sv ----
// Self-checking bench for the flash sequencer.
`timescale 1ns/1ps
`include "pfoc_consts.vh"
module tb_top;
    localparam logic [15:0] CT = `PFOC_OFS_CONTROL;
    localparam logic [15:0] AD = `PFOC_OFS_ADDR;
    localparam logic [15:0] KY = `PFOC_OFS_KEY;
    logic clk = 0, srst = 1, por = 1, hsel = 0, hwrite = 0;
    logic low_supply = 0, fail_mode = 0, slow = 0, dph_rd = 0, err_e;
    logic [31:0] haddr = 0, hwdata = 0, r, m, k, d;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [63:0] page_protect = 64'h1;
    logic [3:0] op_t [0:8] = '{1, 3, 4, 0, 5, 0, 2, 6, 1};
    logic [15:0] ad_t [0:8] = '{16'h1000, 16'h1200, 0, 0, 0, 0, 0, 0,
        16'h1000};
    wire hreadyout, hresp, flash_done, flash_fail, flash_go, busy, det;
    wire [31:0] hrdata;
    wire [3:0] flash_op;
    logic [31:0] exp_q[$];
    int n_errors = 0, checks = 0, i;
    always #10 clk = ~clk;
    pfoc_program_flash_op_controller #(.WORD_CYC(4), .ROW_CYC(6),
        .PAGE_CYC(8), .ALL_CYC(10)) dut_u (.clk(clk), .srst(srst),
        .por(por), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .page_protect(page_protect),
        .low_supply(low_supply), .flash_done(flash_done),
        .flash_fail(flash_fail), .flash_go(flash_go), .flash_op(flash_op),
        .flash_addr(), .flash_wdata(), .flash_src(),
        .detector_enable(det), .busy(busy));
    pfoc_flash_model fm_u (.clk(clk), .flash_go(flash_go), .slow(slow),
        .fail_mode(fail_mode), .flash_done(flash_done),
        .flash_fail(flash_fail));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic finish_test;
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One single transfer; the watchdog bounds every wait.
    task automatic bus(input logic w, input logic [15:0] a,
        input logic [31:0] v);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {16'h0000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= v;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Select, arm, unlock and start; the start write must follow the keys.
    task automatic go(input logic [3:0] op, input logic [15:0] a);
        wr(CT + 16'h4, 32'h00004000);
        wr(CT, {28'h0, op});
        wr(AD, {16'h0, a});
        wr(CT + 16'h8, 32'h00004000);
        wr(KY, `PFOC_KEY_FIRST);
        wr(KY, `PFOC_KEY_SECOND);
        wr(CT, {28'h0000C00, op});
    endtask
    task automatic idle_wait;
        do @(posedge clk); while (busy !== 1'b0);
    endtask
    // Read data is taken at the edge that closes the data phase.
    always @(posedge clk) begin
        if (dph_rd)
            chk(hrdata, exp_q.pop_front());
        dph_rd <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    // A hang is cut short long after the tests should have ended.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test;
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'hA26A3A44);
        repeat (20) @(posedge clk);
        srst <= 0;
        por <= 0;
        @(posedge clk);
        for (i = 0; i < 5; i++)
            rd(CT + 16'(i * 16), 32'h0);
        wr(16'hF460, 32'hFFFFFFFF);
        rd(16'hF460, 32'h0);
        wr(CT, 32'hFFFF8FFF);
        rd(CT, 32'h0000000F);
        wr(CT + 16'h8, 32'h00004000);
        wr(CT, 32'h00004003);
        rd(CT, 32'h0000400F);
        r = $urandom;
        m = $urandom;
        k = $urandom;
        d = $urandom;
        wr(AD, r);
        wr(AD + 16'h8, m);
        wr(AD + 16'h4, k);
        wr(AD + 16'hC, m ^ k);
        rd(AD, ((r | m) & ~k) ^ m ^ k);
        wr(`PFOC_OFS_DATA, d);
        err_e = 0;
        // Every code from 0 to 6, with 0 and 1 twice; protection and a failing array set the error.
        for (i = 0; i < 9; i++) begin
            fail_mode <= (i == 8);
            slow <= i[0];
            go(op_t[i], ad_t[i]);
            idle_wait;
            if (op_t[i] == 4'h0)
                err_e = 0;
            else if (op_t[i] != 4'h2 && op_t[i] != 4'h6)
                err_e |= fail_mode || (op_t[i] == 4'h5 ? |page_protect
                    : page_protect[ad_t[i][15:12]]);
            rd(CT, {16'h0, 2'b01, err_e, 9'h0, op_t[i]}); // 14
        end
        low_supply <= 1;
        fail_mode <= 0;
        go(4'h4, 16'h1000);
        idle_wait;
        rd(CT, 32'h00007804);
        low_supply <= 0;
        rd(CT, 32'h00007004);
        go(4'h0, 16'h0);
        idle_wait;
        rd(CT, 32'h00004000);
        wr(KY, `PFOC_KEY_FIRST);
        rd(KY, 32'h0);
        wr(KY, `PFOC_KEY_SECOND);
        wr(CT, 32'h0000C000);
        idle_wait;
        rd(CT, 32'h00004000);
        page_protect <= 64'h0;
        slow <= 1;
        go(4'h5, 16'h1000);
        wr(AD, 32'h00005555);
        idle_wait;
        rd(AD, 32'h00001000);
        rd(CT, 32'h00004005);
        wr(CT + 16'h4, 32'h00004000);
        wr(KY, `PFOC_KEY_FIRST);
        wr(KY, `PFOC_KEY_SECOND);
        wr(CT, 32'h00008001);
        rd(CT, 32'h00000001);
        srst <= 1;
        @(posedge clk);
        srst <= 0;
        @(posedge clk);
        wr(CT + 16'h8, 32'h00004000);
        srst <= 1;
        @(posedge clk);
        srst <= 0;
        @(posedge clk);
        rd(CT, 32'h00000001);
        rd(`PFOC_OFS_DATA, d);
        @(posedge clk);
        finish_test;
    end
endmodule // tb_top
